/* hdl/tps_map.svh */
// constants of the trip pulse and reset supervisor
// Functional notes
// - hold reset low while feedback low
// - release reset after selectable rising delay
// - assert reset after ten microsecond falling delay
// - trip when comparator holds for deglitch time
// - above high or below low trips
// - trip pulse 10 ms high, 6 ms low
// - gate drive is pulse OR external trip
// - ignore trips during 16 ms period
// - restart pulse if trip still present
// - latch low when trip cleared
// - overtemperature disables functions, forces shunt high
// - exit shutdown only below lower threshold
// - soft start and power-up after shutdown
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH
`define TPS_CLK_KHZ 40000
`define TPS_RISE_US_0 500
`define TPS_RISE_US_1 1000
`define TPS_RISE_US_2 2000
`define TPS_RISE_US_3 5000
`define TPS_RISE_CYC(us) (((us) * `TPS_CLK_KHZ + 999) / 1000)
`define TPS_FALL_US 10
`define TPS_FALL_CYC ((`TPS_FALL_US * `TPS_CLK_KHZ + 999) / 1000)
`define TPS_DEGLITCH_US 20
`define TPS_DEGLITCH_CYC ((`TPS_DEGLITCH_US * `TPS_CLK_KHZ + 999) / 1000)
`define TPS_HIGH_MS 10
`define TPS_LOW_MS 6
`define TPS_HIGH_CYC (`TPS_HIGH_MS * `TPS_CLK_KHZ)
`define TPS_PERIOD_CYC ((`TPS_HIGH_MS + `TPS_LOW_MS) * `TPS_CLK_KHZ)
`define TPS_SOFT_US 1600
`define TPS_SOFT_CYC ((`TPS_SOFT_US * `TPS_CLK_KHZ + 999) / 1000)
`endif

/* hdl/tps_pkg.sv */
// types of the trip pulse and reset supervisor
package tps_pkg;
	typedef enum logic [1:0] {TRIP_IDLE, TRIP_PULSE} tps_trip_t;
	typedef enum logic [1:0] {THM_RUN, THM_SHUT, THM_RECOVER} tps_thm_t;
endpackage

/* hdl/tps_deglitch.sv */
// one comparator deglitch filter
`timescale 1ns/1ps
module tps_deglitch #(
	parameter int CYC = 800
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// comparator in, filtered out
	input wire logic cmp_in,
	output logic cmp_ok
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	always_comb begin
		if (!cmp_in) begin
			cnt_next = 16'h0000;
		end else if (cnt_reg != 16'(CYC)) begin
			cnt_next = cnt_reg + 16'h0001;
		end else begin
			cnt_next = cnt_reg;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	assign cmp_ok = (cnt_reg == 16'(CYC));
endmodule

/* hdl/tps_top.sv */
// reset supervisor, analog trip sequencer and thermal shutdown
`timescale 1ns/1ps
`include "tps_map.svh"
module tps_top #(
	parameter int RISE_UNIT_CYC = `TPS_RISE_CYC(`TPS_RISE_US_0),
	parameter int HIGH_CYC = `TPS_HIGH_CYC,
	parameter int PERIOD_CYC = `TPS_PERIOD_CYC,
	parameter int SOFT_CYC = `TPS_SOFT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// supervisor
	input wire logic buck_feedback,
	input wire logic [1:0] rise_delay_sel,
	output logic reset_out_n_o,
	output logic reset_out_n_oe,
	// trip comparators, one bit per amplifier
	input wire logic [3:0] above_high_trip_threshold,
	input wire logic [3:0] below_low_trip_threshold,
	input wire logic external_trip_in,
	output logic gate_drive,
	output logic trip_pulse,
	// thermal
	input wire logic over_temp_150,
	input wire logic under_temp_135,
	output logic shunt_driver_force,
	output logic functions_enable,
	output logic soft_start
);
	// longer delays scale from the shortest, so one override shortens all four
	localparam int RISE_CYC_0 = RISE_UNIT_CYC;
	localparam int RISE_CYC_1 = RISE_UNIT_CYC * (`TPS_RISE_US_1 / `TPS_RISE_US_0);
	localparam int RISE_CYC_2 = RISE_UNIT_CYC * (`TPS_RISE_US_2 / `TPS_RISE_US_0);
	localparam int RISE_CYC_3 = RISE_UNIT_CYC * (`TPS_RISE_US_3 / `TPS_RISE_US_0);

	// thermal state; shutdown drops the supervisor and blocks new and repeat trip pulses, a running period finishes
	tps_pkg::tps_thm_t thm_reg, thm_next;
	logic [23:0] soft_reg, soft_next;
	always_comb begin
		thm_next = thm_reg;
		soft_next = soft_reg;
		case (thm_reg)
			tps_pkg::THM_RUN: begin
				if (over_temp_150) begin
					thm_next = tps_pkg::THM_SHUT;
				end
			end
			tps_pkg::THM_SHUT: begin
				if (under_temp_135) begin
					thm_next = tps_pkg::THM_RECOVER;
					soft_next = 24'h00_0000;
				end
			end
			tps_pkg::THM_RECOVER: begin
				if (over_temp_150) begin
					thm_next = tps_pkg::THM_SHUT;
				end else if (soft_reg == 24'(SOFT_CYC - 1)) begin
					thm_next = tps_pkg::THM_RUN;
				end else begin
					soft_next = soft_reg + 24'h00_0001;
				end
			end
			default: thm_next = tps_pkg::THM_SHUT;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			thm_reg <= tps_pkg::THM_RECOVER;
			soft_reg <= 24'h00_0000;
		end else begin
			thm_reg <= thm_next;
			soft_reg <= soft_next;
		end
	end
	logic in_shut;
	assign in_shut = (thm_reg == tps_pkg::THM_SHUT);
	assign shunt_driver_force = in_shut;
	assign functions_enable = (thm_reg == tps_pkg::THM_RUN);
	assign soft_start = (thm_reg == tps_pkg::THM_RECOVER);

	// supervisor; delay select taken once after reset release
	logic [1:0] sel_reg, sel_next;
	logic sel_done_reg, sel_done_next;
	logic rst_low_reg, rst_low_next;
	logic [23:0] sup_cnt_reg, sup_cnt_next;
	logic [23:0] rise_cyc;
	always_comb begin
		case (sel_reg)
			2'h0: rise_cyc = 24'(RISE_CYC_0);
			2'h1: rise_cyc = 24'(RISE_CYC_1);
			2'h2: rise_cyc = 24'(RISE_CYC_2);
			default: rise_cyc = 24'(RISE_CYC_3);
		endcase
	end
	always_comb begin
		sel_next = sel_reg;
		sel_done_next = 1'b1;
		rst_low_next = rst_low_reg;
		sup_cnt_next = 24'h00_0000;
		if (!sel_done_reg) begin
			sel_next = rise_delay_sel;
		end
		if (!functions_enable) begin
			rst_low_next = 1'b1;
		end else if (rst_low_reg) begin
			if (buck_feedback) begin
				sup_cnt_next = sup_cnt_reg + 24'h00_0001;
				if (sup_cnt_reg == rise_cyc - 24'h00_0001) begin
					rst_low_next = 1'b0;
				end
			end
		end else if (!buck_feedback) begin
			sup_cnt_next = sup_cnt_reg + 24'h00_0001;
			if (sup_cnt_reg == 24'(`TPS_FALL_CYC - 1)) begin
				rst_low_next = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel_reg <= 2'h0;
			sel_done_reg <= 1'b0;
			rst_low_reg <= 1'b1;
			sup_cnt_reg <= 24'h00_0000;
		end else begin
			sel_reg <= sel_next;
			sel_done_reg <= sel_done_next;
			rst_low_reg <= rst_low_next;
			sup_cnt_reg <= sup_cnt_next;
		end
	end
	// open drain: only ever drives low
	assign reset_out_n_o = 1'b0;
	assign reset_out_n_oe = rst_low_reg;

	// checker helper: run of consecutive low feedback samples in run state
	logic [15:0] low_run_reg, low_run_next;
	always_comb begin
		low_run_next = 16'h0000;
		if (functions_enable && !buck_feedback) begin
			if (low_run_reg != 16'hffff) begin
				low_run_next = low_run_reg + 16'h0001;
			end else begin
				low_run_next = low_run_reg;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			low_run_reg <= 16'h0000;
		end else begin
			low_run_reg <= low_run_next;
		end
	end

	// deglitch, one filter per amplifier
	logic [3:0] amp_ok;
	genvar g;
	for (g = 0; g < 4; g++) begin : g_flt
		tps_deglitch #(
			.CYC(`TPS_DEGLITCH_CYC)
		) u_flt (
			.clk(clk),
			.reset_n(reset_n),
			.cmp_in(above_high_trip_threshold[g] | below_low_trip_threshold[g]),
			.cmp_ok(amp_ok[g])
		);
	end
	logic trip_det;
	assign trip_det = |amp_ok;

	// trip pulse sequencer
	tps_pkg::tps_trip_t trip_reg, trip_next;
	logic [19:0] per_reg, per_next;
	logic pulse_reg, pulse_next;
	always_comb begin
		trip_next = trip_reg;
		per_next = per_reg;
		pulse_next = 1'b0;
		case (trip_reg)
			tps_pkg::TRIP_IDLE: begin
				if (trip_det && functions_enable) begin
					trip_next = tps_pkg::TRIP_PULSE;
					per_next = 20'h0_0000;
					pulse_next = 1'b1;
				end
			end
			tps_pkg::TRIP_PULSE: begin
				// trip input not looked at until period ends
				if (per_reg == 20'(PERIOD_CYC - 1)) begin
					per_next = 20'h0_0000;
					if (trip_det && functions_enable) begin
						pulse_next = 1'b1;
					end else begin
						trip_next = tps_pkg::TRIP_IDLE;
					end
				end else begin
					per_next = per_reg + 20'h0_0001;
					pulse_next = (per_reg < 20'(HIGH_CYC - 1));
				end
			end
			default: trip_next = tps_pkg::TRIP_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			trip_reg <= tps_pkg::TRIP_IDLE;
			per_reg <= 20'h0_0000;
			pulse_reg <= 1'b0;
		end else begin
			trip_reg <= trip_next;
			per_reg <= per_next;
			pulse_reg <= pulse_next;
		end
	end
	assign trip_pulse = pulse_reg;
	assign gate_drive = pulse_reg | external_trip_in;

	property p_fall_delay;
		@(posedge clk) disable iff (!reset_n)
		(functions_enable && !rst_low_reg) ##1 rst_low_reg
		|-> low_run_reg == 16'(`TPS_FALL_CYC);
	endproperty
	a_fall_delay: assert property (p_fall_delay) else $error("reset fell too early");
	property p_shut_force;
		@(posedge clk) disable iff (!reset_n)
		in_shut |-> (shunt_driver_force && !functions_enable) ##1 rst_low_reg;
	endproperty
	a_shut_force: assert property (p_shut_force) else $error("shutdown not enforced");
	property p_low_holds_reset;
		@(posedge clk) disable iff (!reset_n)
		(rst_low_reg && !buck_feedback) |=> rst_low_reg;
	endproperty
	a_low_holds_reset: assert property (p_low_holds_reset) else $error("reset released low");
	property p_pulse_start;
		@(posedge clk) disable iff (!reset_n)
		(trip_reg == tps_pkg::TRIP_IDLE && trip_det && functions_enable) |=> pulse_reg;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("trip gave no pulse");
	property p_gate_or;
		@(posedge clk) disable iff (!reset_n)
		external_trip_in |-> gate_drive;
	endproperty
	a_gate_or: assert property (p_gate_or) else $error("gate not driven");
	property p_low_phase;
		@(posedge clk) disable iff (!reset_n)
		(trip_reg == tps_pkg::TRIP_PULSE && per_reg == 20'(HIGH_CYC)) |-> !pulse_reg;
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("pulse high in low phase");
	property p_latch_low;
		@(posedge clk) disable iff (!reset_n)
		(trip_reg == tps_pkg::TRIP_PULSE && per_reg == 20'(PERIOD_CYC - 1) && !trip_det)
		|=> !pulse_reg && trip_reg == tps_pkg::TRIP_IDLE;
	endproperty
	a_latch_low: assert property (p_latch_low) else $error("pulse not latched low");
	property p_repeat;
		@(posedge clk) disable iff (!reset_n)
		(trip_reg == tps_pkg::TRIP_PULSE && per_reg == 20'(PERIOD_CYC - 1)
			&& trip_det && functions_enable) |=> pulse_reg && per_reg == 20'h0_0000;
	endproperty
	a_repeat: assert property (p_repeat) else $error("no repeat pulse");
	property p_stay_shut;
		@(posedge clk) disable iff (!reset_n)
		(in_shut && !under_temp_135) |=> in_shut;
	endproperty
	a_stay_shut: assert property (p_stay_shut) else $error("left shutdown early");
endmodule

/* verif/tps_actuator_model.sv */
// behavioural actuator gate: counts firing edges seen on the gate line
`timescale 1ns/1ps
module tps_actuator_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// gate line from the block
	input wire logic gate,
	output logic [31:0] fire_count
);
	logic gate_last;

	// a thyristor only reacts to a new rising gate edge
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gate_last <= 1'b0;
			fire_count <= 32'h0000_0000;
		end else begin
			gate_last <= gate;
			if (gate && !gate_last)
				fire_count <= fire_count + 32'h0000_0001;
		end
	end
endmodule

/* verif/tps_top_tb.sv */
// self-checking bench of the trip pulse and reset supervisor
`timescale 1ns/1ps
module tps_top_tb;
	logic clk, reset_n, buck_feedback, external_trip_in, over_temp_150, under_temp_135;
	logic [1:0] rise_delay_sel;
	logic [3:0] above_high_trip_threshold, below_low_trip_threshold;
	logic reset_out_n_o, reset_out_n_oe, gate_drive, trip_pulse;
	logic shunt_driver_force, functions_enable, soft_start;
	logic [31:0] fire_count;
	int n_errors = 0;
	int checks = 0;
	int rise_cyc[4] = '{20, 40, 80, 200};

	tps_top #(.RISE_UNIT_CYC(20), .HIGH_CYC(40), .PERIOD_CYC(64), .SOFT_CYC(30))
		u_dut (.clk(clk), .reset_n(reset_n),
		.buck_feedback(buck_feedback), .rise_delay_sel(rise_delay_sel),
		.reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
		.above_high_trip_threshold(above_high_trip_threshold),
		.below_low_trip_threshold(below_low_trip_threshold),
		.external_trip_in(external_trip_in), .gate_drive(gate_drive),
		.trip_pulse(trip_pulse), .over_temp_150(over_temp_150),
		.under_temp_135(under_temp_135), .shunt_driver_force(shunt_driver_force),
		.functions_enable(functions_enable), .soft_start(soft_start));
	tps_actuator_model u_act (.clk(clk), .reset_n(reset_n), .gate(gate_drive),
		.fire_count(fire_count));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic wrap_up;
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	// bounded wait on run state or on the trip pulse
	task automatic wait_sig(input bit on_trip, input int limit);
		for (int i = 0; i < limit; i++) begin
			if ((on_trip ? trip_pulse : functions_enable) === 1'b1)
				return;
			tick(1);
		end
		n_errors++;
		$display("CHECK FAILED wait expected 1 seen 0");
		wrap_up();
	endtask

	task automatic do_reset(input logic [1:0] sel);
		reset_n = 1'b0;
		rise_delay_sel = sel;
		tick(6);
		reset_n = 1'b1;
		wait_sig(0, 100);
	endtask

	task automatic t_rise(input logic [1:0] sel);
		do_reset(sel);
		tick(rise_cyc[sel] - 3);
		chk_bit("oe_before_rise", 1'b1, reset_out_n_oe);
		chk_bit("oe_data", 1'b0, reset_out_n_o);
		tick(6);
		chk_bit("oe_after_rise", 1'b0, reset_out_n_oe);
	endtask

	task automatic t_fall;
		buck_feedback = 1'b0;
		tick(300);
		buck_feedback = 1'b1;
		tick(2);
		chk_bit("oe_glitch", 1'b0, reset_out_n_oe);
		buck_feedback = 1'b0;
		tick(395);
		chk_bit("oe_before_fall", 1'b0, reset_out_n_oe);
		tick(10);
		chk_bit("oe_low_fb", 1'b1, reset_out_n_oe);
		buck_feedback = 1'b1;
		tick(25);
		chk_bit("oe_release", 1'b0, reset_out_n_oe);
	endtask

	task automatic t_trip(input int b);
		logic [31:0] fires;
		fires = fire_count;
		if (b < 4) above_high_trip_threshold[b] = 1'b1;
		else below_low_trip_threshold[b - 4] = 1'b1;
		tick(790);
		chk_bit("pulse_early", 1'b0, trip_pulse);
		wait_sig(1, 30);
		tick(20);
		chk_bit("gate_high", 1'b1, gate_drive);
		chk_bit("fired", 1'b1, fire_count != fires);
		tick(30);
		chk_bit("pulse_low", 1'b0, trip_pulse);
		tick(20);
		chk_bit("pulse_again", 1'b1, trip_pulse);
		above_high_trip_threshold = 4'h0;
		below_low_trip_threshold = 4'h0;
		tick(60);
		chk_bit("pulse_latched", 1'b0, trip_pulse);
		tick(64);
		chk_bit("gate_idle", 1'b0, gate_drive);
	endtask

	task automatic t_glitch_ext;
		above_high_trip_threshold = 4'h1;
		tick(400);
		chk_bit("glitch_hold", 1'b0, trip_pulse);
		above_high_trip_threshold = 4'h0;
		tick(900);
		chk_bit("glitch_pulse", 1'b0, trip_pulse);
		external_trip_in = 1'b1;
		tick(1);
		chk_bit("gate_ext", 1'b1, gate_drive);
		external_trip_in = 1'b0;
		tick(1);
		chk_bit("gate_ext_off", 1'b0, gate_drive);
	endtask

	task automatic t_thermal;
		over_temp_150 = 1'b1;
		tick(2);
		chk_bit("shunt_hot", 1'b1, shunt_driver_force);
		chk_bit("func_hot", 1'b0, functions_enable);
		chk_bit("oe_hot", 1'b1, reset_out_n_oe);
		over_temp_150 = 1'b0;
		tick(10);
		chk_bit("shunt_hyst", 1'b1, shunt_driver_force);
		under_temp_135 = 1'b1;
		tick(3);
		chk_bit("soft_start", 1'b1, soft_start);
		chk_bit("func_soft", 1'b0, functions_enable);
		tick(35);
		chk_bit("func_back", 1'b1, functions_enable);
	endtask

	initial begin
		reset_n = 1'b0;
		buck_feedback = 1'b1;
		rise_delay_sel = 2'h0;
		above_high_trip_threshold = 4'h0;
		below_low_trip_threshold = 4'h0;
		external_trip_in = 1'b0;
		over_temp_150 = 1'b0;
		under_temp_135 = 1'b1;
		for (int s = 3; s >= 0; s--)
			t_rise(2'(s));
		t_fall();
		t_glitch_ext();
		for (int b = 0; b < 8; b++)
			t_trip(b);
		under_temp_135 = 1'b0;
		t_thermal();
		wrap_up();
	end
endmodule
